/* psc_board_model.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// Board controller on the configuration pins
// ------------------------------------------------------------
module psc_board_model (
	input  wire logic       clock,
	output logic            parLoadN,
	output logic      [6:0] fbDivPin,
	output logic      [6:0] fbDivDriven,
	output logic      [1:0] outSelPin,
	output logic      [1:0] outSelDriven,
	output logic            serClk,
	output logic            serData,
	output logic            serLoad
);
	// Power-up: load held low, divider pins floating
	initial begin
		parLoadN     = 1'h0;
		fbDivPin     = 7'h00;
		fbDivDriven  = 7'h00;
		outSelPin    = 2'h0;
		outSelDriven = 2'h0;
		serClk       = 1'h0;
		serData      = 1'h0;
		serLoad      = 1'h0;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clock);
	endtask : hold

	// Drive divider pins with the load low
	task automatic parDrive(input logic [6:0] m, input logic [1:0] n);
		@(posedge clock);
		parLoadN     <= 1'h0;
		fbDivPin     <= m;
		fbDivDriven  <= 7'h7F;
		outSelPin    <= n;
		outSelDriven <= 2'h3;
		hold(10);
	endtask : parDrive

	// Rising load edge, then pins released to their pull-ups
	task automatic parLoad(input logic [6:0] m, input logic [1:0] n);
		parDrive(m, n);
		parLoadN     <= 1'h1;
		hold(10);
		fbDivPin     <= ~m;
		fbDivDriven  <= 7'h00;
		outSelDriven <= 2'h0;
		hold(10);
	endtask : parLoad

	// One frame, first bit first, 160 ns shift period
	task automatic sendWord(input logic [13:0] w);
		for (int i = 13; i >= 0; i--) begin
			serData <= w[i];
			hold(4);
			serClk  <= 1'h1;
			hold(8);
			serClk  <= 1'h0;
			hold(4);
		end
		serData <= ~w[0];
		serLoad <= 1'h1;
		hold(8);
		serLoad <= 1'h0;
		hold(8);
	endtask : sendWord
endmodule : psc_board_model

/* psc_cfg.svh */
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH

// ------------------------------------------------------------
// Register map (byte addresses)
// ------------------------------------------------------------
`define PSC_ADDR_REF       12'h000
`define PSC_ADDR_STATUS    12'h004
`define PSC_ADDR_SHIFT     12'h008

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PSC_REF_MHZ_RST    8'h10
`define PSC_M_RST          7'h7F
`define PSC_N_RST          2'h3

// ------------------------------------------------------------
// Status field positions
// ------------------------------------------------------------
`define PSC_ST_M_LSB       0
`define PSC_ST_N_LSB       8
`define PSC_ST_T_LSB       12
`define PSC_ST_VCO_OK      16
`define PSC_ST_LOCKED      17
`define PSC_ST_PLOAD       18

// ------------------------------------------------------------
// Serial word field positions
// ------------------------------------------------------------
`define PSC_SH_T_MSB       13
`define PSC_SH_T_LSB       11
`define PSC_SH_N_MSB       10
`define PSC_SH_N_LSB       9
`define PSC_SH_M_MSB       6

// ------------------------------------------------------------
// Oscillator range and timing
// ------------------------------------------------------------
`define PSC_VCO_MIN_MHZ    15'h0190
`define PSC_VCO_MAX_MHZ    15'h0320
`define PSC_LOCK_TIME_MS   10
`define PSC_CLK_PERIOD_NS  10

`endif

/* psc_ctl_chk.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// Bus and configuration checks
// ------------------------------------------------------------
module psc_ctl_chk #(
	parameter int unsigned LOCK_CYCLES = 50
) (
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        lockDone
);
	logic [19:0] lowCnt_r;

	// Cycles spent waiting for lock, saturating
	always_ff @(posedge clock) begin
		if (!rstn || lockDone)
			lowCnt_r <= 20'h0;
		else if (lowCnt_r != 20'hFFFFF)
			lowCnt_r <= lowCnt_r + 20'h1;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence sAccess;
		psel && penable && !pready;
	endsequence
	sequence sRead(logic [11:0] a);
		pready && !pwrite && paddr == a;
	endsequence

	chk_ready_next: assert property (sAccess |=> pready) else $error("ready missing");
	chk_ready_cause: assert property (pready |-> $past(psel && penable))
		else $error("ready without access");
	chk_ready_once: assert property (pready |=> !pready) else $error("ready held");
	chk_err_addr: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}))
		else $error("error flag wrong");
	chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0) else $error("error data");
	chk_ref_width: assert property (sRead(12'h000) |-> prdata[31:8] == 24'h0)
		else $error("reference upper bits");
	chk_shift_width: assert property (sRead(12'h008) |-> prdata[31:14] == 18'h0)
		else $error("shift upper bits");
	chk_status_gap: assert property (sRead(12'h004) |-> prdata[7] == 1'h0 && prdata[11:10] == 2'h0)
		else $error("status gap bits");
	chk_test_forced: assert property (sRead(12'h004) ##0 !prdata[18] |-> prdata[14:12] == 3'h0)
		else $error("test select not cleared");
	chk_lock_wait: assert property ($rose(lockDone) |-> lowCnt_r >= LOCK_CYCLES - 1)
		else $error("lock too early");
endmodule : psc_ctl_chk

bind psc_synth_ctrl psc_ctl_chk #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (
	.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lockDone(lockDone));

/* psc_pkg.sv */
package psc_pkg;

	// Observation output selection codes
	typedef enum logic [2:0] {
		PSC_T_SHIFT  = 3'b000,
		PSC_T_HIGH   = 3'b001,
		PSC_T_FREF   = 3'b010,
		PSC_T_MCNT   = 3'b011,
		PSC_T_SYNTH_CLOCK_OUT   = 3'b100,
		PSC_T_LOW    = 3'b101,
		PSC_T_BYPASS = 3'b110,
		PSC_T_FDIV4  = 3'b111
	} psc_tsel_t;

	// Configuration pins after pull-up resolution
	typedef struct packed {
		logic       parLoadN;
		logic       serClk;
		logic       serData;
		logic       serLoad;
		logic       refIn;
		logic [6:0] fbDiv;
		logic [1:0] outSel;
	} psc_pins_t;

	// APB request bundle
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} psc_apb_req_t;

	// Whole state of the synthesizer control logic
	typedef struct packed {
		psc_pins_t  s1;
		psc_pins_t  s2;
		psc_pins_t  prev;
		logic [13:0] shiftReg;
		logic [6:0] cfgM;
		logic [1:0] cfgN;
		psc_tsel_t  cfgT;
		logic       refHalf;
		logic [6:0] fbCnt;
		logic       fbOut;
		logic [2:0] outCnt;
		logic       outClk;
		logic [1:0] quarterCnt;
		logic       outDiv4;
		logic [19:0] lockCnt;
		logic       locked;
		logic       vcoOk;
		logic       testOut;
		logic [7:0] refMhz;
		logic       pready;
		logic       pslverr;
		logic [31:0] prdata;
	} psc_state_t;

endpackage : psc_pkg

/* psc_synth_ctrl.sv */
`timescale 1ns/10ps
`include "psc_cfg.svh"

module psc_synth_ctrl
	import psc_pkg::*;
#(
	parameter int unsigned LOCK_CYCLES = `PSC_LOCK_TIME_MS * 1000000 / `PSC_CLK_PERIOD_NS
) (
	input  wire logic        clock,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Configuration pins
	input  wire logic        parLoadN,
	input  wire logic [6:0]  fbDivPin,
	input  wire logic [6:0]  fbDivDriven,
	input  wire logic [1:0]  outSelPin,
	input  wire logic [1:0]  outSelDriven,
	input  wire logic        serClk,
	input  wire logic        serData,
	input  wire logic        serLoad,
	// Reference and oscillator model
	input  wire logic        external_reference_in,
	input  wire logic        vcoTick,
	// Outputs
	output logic             synth_clock_out,
	output logic             testOut,
	output logic             cmpRefOut,
	output logic             fbDivOut,
	output logic             vcoRangeOk,
	output logic             lockDone
);

	// ------------------------------------------------------------
	// Pin resolution and state
	// ------------------------------------------------------------

	psc_pins_t    pinsRaw;
	psc_apb_req_t req;
	psc_state_t   st_r;
	psc_state_t   st_nxt;

	// Pull-ups make undriven divider inputs read high
	// Divider pins are levels; a skewed multi-bit sample lasts one cycle
	always_comb begin
		pinsRaw.parLoadN = parLoadN;
		pinsRaw.serClk   = serClk;
		pinsRaw.serData  = serData;
		pinsRaw.serLoad  = serLoad;
		pinsRaw.refIn    = external_reference_in;
		pinsRaw.fbDiv    = fbDivPin | ~fbDivDriven;
		pinsRaw.outSel   = outSelPin | ~outSelDriven;
	end

	// APB request bundle
	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// Output select to half-period length in oscillator ticks
	function automatic logic [3:0] outRatio(input logic [1:0] sel);
		logic [3:0] r;
		r = 4'h1;
		case (sel)
			2'b00:   r = 4'h2;
			2'b01:   r = 4'h4;
			2'b10:   r = 4'h8;
			default: r = 4'h1;
		endcase
		return r;
	endfunction : outRatio

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------

	logic        serClkRise;
	logic        serClkEdge;
	logic        serLoadFall;
	logic        refRise;
	logic        tick;
	logic        addrHit;
	logic [14:0] vcoMhz;
	logic [3:0]  ratio;
	logic [31:0] status;

	// Edge detection on synchronised pins
	// Idle reset levels of the stages keep false edges away
	always_comb begin
		serClkRise  = st_r.s2.serClk & ~st_r.prev.serClk;
		serClkEdge  = st_r.s2.serClk ^ st_r.prev.serClk;
		serLoadFall = ~st_r.s2.serLoad & st_r.prev.serLoad;
		refRise     = st_r.s2.refIn & ~st_r.prev.refIn;
		// Bypass feeds both serial clock edges in place of the oscillator
		tick        = (st_r.cfgT == PSC_T_BYPASS) ? serClkEdge : vcoTick;
		ratio       = outRatio(st_r.cfgN);
		// Both operands widened so the product keeps all 15 bits
		vcoMhz      = {7'h00, st_r.refMhz} * {8'h00, st_r.cfgM};
	end

	// Status word
	// Load bit taken one stage late, in step with the test select clear
	always_comb begin
		status                                   = 32'h0000_0000;
		status[`PSC_ST_M_LSB +: 7]               = st_r.cfgM;
		status[`PSC_ST_N_LSB +: 2]               = st_r.cfgN;
		status[`PSC_ST_T_LSB +: 3]               = st_r.cfgT;
		status[`PSC_ST_VCO_OK]                   = st_r.vcoOk;
		status[`PSC_ST_LOCKED]                   = st_r.locked;
		status[`PSC_ST_PLOAD]                    = st_r.prev.parLoadN;
	end

	always_comb begin
		st_nxt = st_r;

		// ------------------------------------------------------------
		// Synchronisers
		// ------------------------------------------------------------

		// Two-stage synchronisers; prev holds the last settled sample
		st_nxt.s1   = pinsRaw;
		st_nxt.s2   = st_r.s1;
		st_nxt.prev = st_r.s2;

		// ------------------------------------------------------------
		// Serial path
		// ------------------------------------------------------------

		// Serial shift: new bit at the LSB end
		if (serClkRise) begin
			st_nxt.shiftReg = {st_r.shiftReg[12:0], st_r.s2.serData};
		end

		// ------------------------------------------------------------
		// Divider and test configuration
		// ------------------------------------------------------------

		// Configuration latches
		// Serial load is ignored while the parallel path is active
		if (!st_r.s2.parLoadN) begin
			// Transparent parallel path; capture happens as it rises
			st_nxt.cfgM = st_r.s2.fbDiv;
			st_nxt.cfgN = st_r.s2.outSel;
			st_nxt.cfgT = PSC_T_SHIFT;
		end else if (serLoadFall) begin
			// Field order in the serial word: test, output, feedback
			st_nxt.cfgT = psc_tsel_t'(st_r.shiftReg[`PSC_SH_T_MSB:`PSC_SH_T_LSB]);
			st_nxt.cfgN = st_r.shiftReg[`PSC_SH_N_MSB:`PSC_SH_N_LSB];
			st_nxt.cfgM = st_r.shiftReg[`PSC_SH_M_MSB:0];
		end

		// ------------------------------------------------------------
		// Phase detector inputs
		// ------------------------------------------------------------

		// Reference halved for the phase detector
		if (refRise) begin
			st_nxt.refHalf = ~st_r.refHalf;
		end

		// ------------------------------------------------------------
		// Feedback divider
		// ------------------------------------------------------------

		// Feedback divider: toggles every cfgM ticks, so output is fvco / (2 * M)
		// A zero value skips the count, so the divider then holds
		if (tick && st_r.cfgM != 7'h00) begin
			if (st_r.fbCnt + 7'h01 >= st_r.cfgM) begin
				st_nxt.fbCnt = 7'h00;
				st_nxt.fbOut = ~st_r.fbOut;
			end else begin
				st_nxt.fbCnt = st_r.fbCnt + 7'h01;
			end
		end

		// ------------------------------------------------------------
		// Output divider
		// ------------------------------------------------------------

		// Output divider: equal high and low halves
		if (tick) begin
			if ({1'b0, st_r.outCnt} + 4'h1 >= ratio) begin
				st_nxt.outCnt = 3'h0;
				st_nxt.outClk = ~st_r.outClk;
			end else begin
				st_nxt.outCnt = st_r.outCnt + 3'h1;
			end
		end

		// Output divided by four for the observation pin
		// Four output toggles make one half period here
		if (st_nxt.outClk != st_r.outClk) begin
			st_nxt.quarterCnt = st_r.quarterCnt + 2'h1;
			if (st_r.quarterCnt == 2'h3) begin
				st_nxt.outDiv4 = ~st_r.outDiv4;
			end
		end

		// ------------------------------------------------------------
		// Range check
		// ------------------------------------------------------------

		// Oscillator range check
		// Flag is advisory; the dividers still run out of range
		st_nxt.vcoOk = (vcoMhz >= `PSC_VCO_MIN_MHZ) && (vcoMhz <= `PSC_VCO_MAX_MHZ);

		// ------------------------------------------------------------
		// Settling timer
		// ------------------------------------------------------------

		// Settling timer restarts on any divider change
		// Counter stops at its end value; a change clears it again
		if (st_nxt.cfgM != st_r.cfgM || st_nxt.cfgN != st_r.cfgN) begin
			st_nxt.lockCnt = 20'h00000;
			st_nxt.locked  = 1'b0;
		end else if (st_r.lockCnt >= LOCK_CYCLES[19:0] - 20'h00001) begin
			st_nxt.locked  = 1'b1;
		end else begin
			st_nxt.lockCnt = st_r.lockCnt + 20'h00001;
		end

		// ------------------------------------------------------------
		// Observation output
		// ------------------------------------------------------------

		// Observation output selection
		case (st_r.cfgT)
			PSC_T_SHIFT:  st_nxt.testOut = st_r.shiftReg[13];
			PSC_T_HIGH:   st_nxt.testOut = 1'b1;
			PSC_T_FREF:   st_nxt.testOut = st_r.refHalf;
			PSC_T_MCNT:   st_nxt.testOut = st_r.fbOut;
			PSC_T_SYNTH_CLOCK_OUT:   st_nxt.testOut = st_r.outClk;
			PSC_T_LOW:    st_nxt.testOut = 1'b0;
			PSC_T_BYPASS: st_nxt.testOut = st_r.fbOut;
			PSC_T_FDIV4:  st_nxt.testOut = st_r.outDiv4;
			default:      st_nxt.testOut = 1'b0;
		endcase

		// ------------------------------------------------------------
		// Register access
		// ------------------------------------------------------------

		// APB slave: answers in the second access cycle
		// Response stands for the one cycle of pready; read data holds until the next access
		st_nxt.pready  = 1'b0;
		st_nxt.pslverr = 1'b0;
		if (req.psel && req.penable && !st_r.pready) begin
			st_nxt.pready = 1'b1;
			addrHit       = 1'b1;
			case (req.paddr)
				`PSC_ADDR_REF:    st_nxt.prdata = {24'h000000, st_r.refMhz};
				`PSC_ADDR_STATUS: st_nxt.prdata = status;
				`PSC_ADDR_SHIFT:  st_nxt.prdata = {18'h00000, st_r.shiftReg};
				default: begin
					addrHit       = 1'b0;
					st_nxt.prdata = 32'h0000_0000;
				end
			endcase
			st_nxt.pslverr = ~addrHit;
		end else begin
			addrHit = 1'b0;
		end

		// Write lands at the completion edge, while pready stands
		if (req.psel && req.penable && req.pwrite && st_r.pready) begin
			if (req.paddr == `PSC_ADDR_REF) begin
				st_nxt.refMhz = req.pwdata[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------

	// State register with synchronous reset
	always_ff @(posedge clock) begin
		if (!rstn) begin
			st_r            <= '0;
			st_r.s1         <= '{parLoadN: 1'b1, serClk: 1'b0, serData: 1'b0, serLoad: 1'b0,
			                     refIn: 1'b0, fbDiv: `PSC_M_RST, outSel: `PSC_N_RST};
			st_r.s2         <= '{parLoadN: 1'b1, serClk: 1'b0, serData: 1'b0, serLoad: 1'b0,
			                     refIn: 1'b0, fbDiv: `PSC_M_RST, outSel: `PSC_N_RST};
			st_r.prev       <= '{parLoadN: 1'b1, serClk: 1'b0, serData: 1'b0, serLoad: 1'b0,
			                     refIn: 1'b0, fbDiv: `PSC_M_RST, outSel: `PSC_N_RST};
			st_r.cfgM       <= `PSC_M_RST;
			st_r.cfgN       <= `PSC_N_RST;
			st_r.cfgT       <= PSC_T_SHIFT;
			st_r.refMhz     <= `PSC_REF_MHZ_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs straight from the state register
	// ------------------------------------------------------------

	assign prdata          = st_r.prdata;
	assign pready          = st_r.pready;
	assign pslverr         = st_r.pslverr;
	assign synth_clock_out = st_r.outClk;
	assign testOut         = st_r.testOut;
	assign cmpRefOut       = st_r.refHalf;
	assign fbDivOut        = st_r.fbOut;
	assign vcoRangeOk      = st_r.vcoOk;
	assign lockDone        = st_r.locked;

endmodule : psc_synth_ctrl

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
	typedef struct {logic [6:0] m; logic [1:0] n; logic ok; int outTog;} psc_row_t;
	logic        clock, rstn, psel, penable, pwrite, vcoTick, counting, errF;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic        pready, pslverr, synthOut, testOut, cmpRef, fbOut, rangeOk, lockDone;
	logic        parLoadN, serClk, serData, serLoad, sO, sF, sR;
	logic [6:0]  fbDivPin, fbDivDriven;
	logic [1:0]  outSelPin, outSelDriven;
	logic [2:0]  refCnt;
	int          failCount, checksDone, cO, cF, cR;
	psc_row_t    rows [4] = '{'{7'h18, 2'h0, 1'h0, 96}, '{7'h19, 2'h1, 1'h1, 50},
		'{7'h32, 2'h2, 1'h1, 50}, '{7'h33, 2'h3, 1'h0, 408}};

	psc_synth_ctrl #(.LOCK_CYCLES(50)) dut (
		.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.parLoadN(parLoadN), .fbDivPin(fbDivPin), .fbDivDriven(fbDivDriven),
		.outSelPin(outSelPin), .outSelDriven(outSelDriven), .serClk(serClk),
		.serData(serData), .serLoad(serLoad), .external_reference_in(refCnt[2]),
		.vcoTick(vcoTick), .synth_clock_out(synthOut), .testOut(testOut),
		.cmpRefOut(cmpRef), .fbDivOut(fbOut), .vcoRangeOk(rangeOk), .lockDone(lockDone));
	psc_board_model model (
		.clock(clock), .parLoadN(parLoadN), .fbDivPin(fbDivPin), .fbDivDriven(fbDivDriven),
		.outSelPin(outSelPin), .outSelDriven(outSelDriven), .serClk(serClk),
		.serData(serData), .serLoad(serLoad));

	initial begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end

	// Oscillator tick every other cycle, reference period 8 cycles; toggle counting
	always @(posedge clock) begin
		vcoTick <= ~vcoTick;
		refCnt  <= refCnt + 3'h1;
		sO      <= synthOut;
		sF      <= fbOut;
		sR      <= cmpRef;
		if (counting) begin
			cO <= cO + int'(synthOut !== sO);
			cF <= cF + int'(fbOut !== sF);
			cR <= cR + int'(cmpRef !== sR);
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			failCount++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clock);
		psel    <= 1'h1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clock);
		penable <= 1'h1;
		// Waits for the slave; only the watchdog ends a hang
		do begin
			@(posedge clock);
		end while (pready !== 1'h1);
		rdat = prdata;
		errF = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic readChk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		check(rdat, exp);
	endtask : readChk

	task automatic stChk(input logic [6:0] m, input logic [1:0] n, input logic [2:0] t);
		apb(1'h0, 12'h004, 32'h0);
		check(rdat & 32'h0000737F, {17'h0, t, 2'h0, n, 1'h0, m});
	endtask : stChk

	task automatic endOfTest();
		if (failCount == 0 && checksDone > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : endOfTest

	initial begin
		#200000;
		failCount++;
		endOfTest();
	end

	initial begin
		{rstn, psel, penable, pwrite, vcoTick, counting} = 6'h0;
		{paddr, pwdata, refCnt} = 47'h0;
		{failCount, checksDone} = 64'h0;
		repeat (3) @(posedge clock);
		rstn <= 1'h1;
		repeat (10) @(posedge clock);
		readChk(12'h000, 32'h00000010);
		stChk(7'h7F, 2'h3, 3'h0);
		apb(1'h0, 12'h00C, 32'h0);
		check(rdat, 32'h0);
		check(errF, 1'h1);
		apb(1'h1, 12'h004, 32'hFFFFFFFF);
		stChk(7'h7F, 2'h3, 3'h0);
		// Parallel loads with divider measurements
		foreach (rows[i]) begin
			model.parLoad(rows[i].m, rows[i].n);
			stChk(rows[i].m, rows[i].n, 3'h0);
			repeat (120) @(posedge clock);
			{cO, cF, cR} = 96'h0;
			counting <= 1'h1;
			repeat (16 * rows[i].m) @(posedge clock);
			counting <= 1'h0;
			@(posedge clock);
			check(cO, rows[i].outTog);
			check(cF, 8);
			check(cR, 2 * rows[i].m);
			check(rangeOk, rows[i].ok);
			if (rows[i].ok)
				check(lockDone, 1'h1);
		end
		// Serial frames for every test select code
		for (int t = 0; t < 8; t++) begin
			model.sendWord({t[2:0], 2'h2, 2'h0, 7'h28});
			stChk(7'h28, 2'h2, t[2:0]);
			readChk(12'h008, {18'h0, t[2:0], 11'h428});
			if (t == 1 || t == 5)
				check(testOut, t == 1);
			// Bypass: dividers run only on serial clock edges
			if (t == 6) begin
				errF = synthOut;
				repeat (48) @(posedge clock);
				check(synthOut, errF);
				check(testOut, fbOut);
			end
		end
		model.parDrive(7'h21, 2'h1);
		model.sendWord({3'h7, 2'h0, 2'h0, 7'h33});
		stChk(7'h21, 2'h1, 3'h0);
		apb(1'h1, 12'h000, 32'h00000030);
		readChk(12'h000, 32'h00000030);
		rstn <= 1'h0;
		repeat (3) @(posedge clock);
		rstn <= 1'h1;
		readChk(12'h000, 32'h00000010);
		endOfTest();
	end
endmodule : testbench
